// ===== include/cmw_pkg.sv
/*
  Constants and types for the command memory access window.
  Assumes one clock domain shared with the host register port and the
  self-test sequencer.
*/
package cmw_pkg;
  // Register select codes on the host register port
  localparam logic [1:0] CMW_SEL_ADDR = 2'h0;
  localparam logic [1:0] CMW_SEL_LOW = 2'h1;
  localparam logic [1:0] CMW_SEL_HIGH = 2'h2;
  // Address-select field position: longword offset in bits 10..2
  localparam int CMW_OFS_MSB = 10;
  localparam int CMW_OFS_LSB = 2;
  localparam int CMW_OFS_W = CMW_OFS_MSB - CMW_OFS_LSB + 1;
  localparam logic [15:0] CMW_OFS_MASK = 16'h07FC;
  // Memory geometry
  localparam int CMW_MEM_BYTES = 2048;
  localparam int CMW_MEM_WORDS = CMW_MEM_BYTES / 2;
  localparam int CMW_WADDR_W = CMW_OFS_W + 1;
  localparam int CMW_UNIT_BYTES = 32;
  localparam int CMW_UNITS = CMW_MEM_BYTES / CMW_UNIT_BYTES;
  // Self-test result codes written into word 0, high-word code into word 1
  localparam logic [15:0] CMW_RES_PASS = 16'hAAAA;
  localparam logic [15:0] CMW_RES_FAIL = 16'h5555;
  localparam logic [15:0] CMW_RES_SKIP = 16'h55AA;
  localparam logic [15:0] CMW_HIGH_CLEAN = 16'h0000;
  // Reset values
  localparam logic [15:0] CMW_RST_WORD = 16'h0000;
  localparam logic [CMW_OFS_W-1:0] CMW_RST_OFS = '0;
  // Self-test outcome reported by the sequencer
  typedef enum logic [1:0] {
    CMW_ST_PASS = 2'h0,
    CMW_ST_FAIL = 2'h1,
    CMW_ST_SKIP = 2'h2
  } cmw_result_t;
  // Window controller states, one-hot
  typedef enum logic [4:0] {
    CMW_IDLE = 5'h01,
    CMW_RDWAIT = 5'h02,
    CMW_INITLO = 5'h04,
    CMW_INITHI = 5'h08,
    CMW_SPARE = 5'h10
  } cmw_state_t;
endpackage

// ===== logic/cmw_mem.sv
/*
  Single-port command memory, 16-bit words, registered read data.
  Assumes one write or one read per cycle from the window controller.
*/
`timescale 1ns/10ps
module cmw_mem
  import cmw_pkg::*;
#(
  parameter int WORDS = CMW_MEM_WORDS,
  parameter int AW = CMW_WADDR_W
)
(
  // Clock
  input wire logic mclk,
  // Access port
  input wire logic [AW-1:0] addr,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem_q [WORDS];
  logic [15:0] rdata_q;

  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem_q[addr] <= wdata;
    end
    rdata_q <= mem_q[addr];
  end

  assign rdata = rdata_q;
endmodule // cmw_mem

// ===== logic/cmw_window.sv
/*
  Indirect access window into the 2048-byte command memory: address-select
  register plus low and high data registers, with self-test result posting.
  Assumes host register strobes and the self-test sequencer share mclk;
  the host waits for ready and for self-test completion before use.
*/
`timescale 1ns/10ps
// Function
// - Address select holds longword offset bits 10:2
// - Address readback comes from separate shadow register
// - Self-test end posts pattern, clears offset, shows version
// - Low data reports pass, fail, skip codes
// - Low data accesses selected longword's first word
// - High data accesses following word of longword
// - High data gives diagnostic code on failure
// - 2048 bytes reachable only through window registers
// - Memory forms 64 units of 32 bytes
// - Elements 32 bytes, linked by memory pointers
module cmw_window
  import cmw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host register port
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic reg_ready,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Self-test sequencer
  input wire logic st_done,
  input wire logic [1:0] st_result,
  input wire logic [15:0] st_diag,
  input wire logic [15:0] fw_version,
  // Status
  output logic init_busy
);
  typedef struct packed {
    cmw_state_t state;
    logic [CMW_OFS_W-1:0] offset;
    logic [15:0] readback;
    logic show_version;
    logic [15:0] result_code;
    logic [15:0] high_code;
    logic [15:0] rdata;
    logic rvalid;
  } cmw_regs_t;

  cmw_regs_t r_q;
  cmw_regs_t r_d;
  logic [CMW_WADDR_W-1:0] mem_addr;
  logic mem_wr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic host_ok;

  // Word index of the selected longword plus the high-word flag
  function automatic logic [CMW_WADDR_W-1:0] word_index(
    input logic [CMW_OFS_W-1:0] ofs,
    input logic high
  );
    word_index = {ofs, high};
  endfunction

  // Result code for the sequencer's outcome
  function automatic logic [15:0] result_word(input logic [1:0] res);
    case (res)
      CMW_ST_PASS: result_word = CMW_RES_PASS;
      CMW_ST_FAIL: result_word = CMW_RES_FAIL;
      default: result_word = CMW_RES_SKIP;
    endcase
  endfunction

  assign host_ok = (r_q.state == CMW_IDLE) && !st_done;

  always_comb
  begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    mem_addr = word_index(r_q.offset, 1'b0);
    mem_wr = 1'b0;
    mem_wdata = reg_wdata;
    case (r_q.state)
      CMW_IDLE:
      begin
        if (st_done)
        begin
          r_d.result_code = result_word(st_result);
          r_d.high_code = (st_result == CMW_ST_FAIL) ? st_diag : CMW_HIGH_CLEAN;
          r_d.state = CMW_INITLO;
        end
        else if (reg_wr)
        begin
          case (reg_sel)
            CMW_SEL_ADDR:
            begin
              r_d.offset = reg_wdata[CMW_OFS_MSB:CMW_OFS_LSB];
              r_d.readback = reg_wdata & CMW_OFS_MASK;
              r_d.show_version = 1'b0;
            end
            CMW_SEL_LOW:
            begin
              mem_addr = word_index(r_q.offset, 1'b0);
              mem_wr = 1'b1;
            end
            CMW_SEL_HIGH:
            begin
              mem_addr = word_index(r_q.offset, 1'b1);
              mem_wr = 1'b1;
            end
            default:
            begin
              mem_wr = 1'b0;
            end
          endcase
        end
        else if (reg_rd)
        begin
          case (reg_sel)
            CMW_SEL_ADDR:
            begin
              r_d.rdata = r_q.show_version ? fw_version : r_q.readback;
              r_d.rvalid = 1'b1;
            end
            CMW_SEL_LOW, CMW_SEL_HIGH:
            begin
              mem_addr = word_index(r_q.offset, reg_sel == CMW_SEL_HIGH);
              r_d.state = CMW_RDWAIT;
            end
            default:
            begin
              r_d.rdata = CMW_RST_WORD;
              r_d.rvalid = 1'b1;
            end
          endcase
        end
      end
      CMW_RDWAIT:
      begin
        r_d.rdata = mem_rdata;
        r_d.rvalid = 1'b1;
        r_d.state = CMW_IDLE;
      end
      CMW_INITLO:
      begin
        mem_addr = word_index(CMW_RST_OFS, 1'b0);
        mem_wdata = r_q.result_code;
        mem_wr = 1'b1;
        r_d.state = CMW_INITHI;
      end
      CMW_INITHI:
      begin
        mem_addr = word_index(CMW_RST_OFS, 1'b1);
        mem_wdata = r_q.high_code;
        mem_wr = 1'b1;
        r_d.offset = CMW_RST_OFS;
        r_d.readback = CMW_RST_WORD;
        r_d.show_version = 1'b1;
        r_d.state = CMW_IDLE;
      end
      default:
      begin
        r_d.state = CMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      r_q.state <= CMW_IDLE;
      r_q.offset <= CMW_RST_OFS;
      r_q.readback <= CMW_RST_WORD;
      r_q.show_version <= 1'b0;
      r_q.result_code <= CMW_RST_WORD;
      r_q.high_code <= CMW_RST_WORD;
      r_q.rdata <= CMW_RST_WORD;
      r_q.rvalid <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  cmw_mem #(
    .WORDS(CMW_MEM_WORDS),
    .AW(CMW_WADDR_W)
  ) u_mem (
    .mclk(mclk),
    .addr(mem_addr),
    .wr_en(mem_wr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign reg_ready = host_ok;
  assign reg_rdata = r_q.rdata;
  assign reg_rvalid = r_q.rvalid;
  assign init_busy = (r_q.state == CMW_INITLO) || (r_q.state == CMW_INITHI);
endmodule // cmw_window

// ===== sim/cmw_window_props.sv
/* Port checker for the command memory access window.
   Assumes it is bound onto cmw_window and sees only its ports. */
`timescale 1ns/10ps
module cmw_window_props
  import cmw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host register port
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_ready,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Self-test
  input wire logic st_done,
  input wire logic [1:0] st_result,
  input wire logic [15:0] st_diag,
  input wire logic [15:0] fw_version,
  input wire logic init_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd_ok = reg_ready && reg_rd && !reg_wr;
  wire wa_ok = reg_ready && reg_wr && reg_sel == CMW_SEL_ADDR;
  property p_ar; rd_ok && reg_sel == CMW_SEL_ADDR |=> reg_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("late select readback");
  property p_dr; rd_ok && (reg_sel[0] ^ reg_sel[1]) |=> !reg_rvalid ##1 reg_rvalid; endproperty
  a_dr: assert property (p_dr) else $error("data read timing");
  property p_ua; rd_ok && reg_sel == 2'h3 |=> reg_rvalid && reg_rdata == 16'h0000; endproperty
  a_ua: assert property (p_ua) else $error("unmapped read not zero");
  property p_wb; wa_ok ##1 !reg_wr ##1 rd_ok && reg_sel == CMW_SEL_ADDR
    |=> reg_rdata == ($past(reg_wdata, 3) & CMW_OFS_MASK); endproperty
  a_wb: assert property (p_wb) else $error("select readback wrong");
  property p_bz; st_done && !init_busy && !$past(rd_ok && (reg_sel[0] ^ reg_sel[1]))
    |=> init_busy [*2] ##1 !init_busy; endproperty
  a_bz: assert property (p_bz) else $error("posting length wrong");
  property p_rf; init_busy |-> !reg_ready; endproperty
  a_rf: assert property (p_rf) else $error("ready while posting");
  property p_hd; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_hd: assert property (p_hd) else $error("read data moved");
  property p_nr; reg_rvalid |-> $past(rd_ok) || $past(rd_ok, 2); endproperty
  a_nr: assert property (p_nr) else $error("valid without read");
endmodule // cmw_window_props
bind cmw_window cmw_window_props u_props (.*);

// ===== sim/cmw_host.sv
/* Host processor model driving the register port.
   Assumes strobes change on the falling edge of mclk. */
`timescale 1ns/10ps
module cmw_host
  import cmw_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port
  output logic [1:0] reg_sel,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic reg_ready,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_sel = 2'h3;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One strobe, raised once ready is seen at a falling edge, held one cycle, then released
  task automatic go(input logic [1:0] s, input logic [15:0] d, input logic w);
    int n;
    n = 0;
    @(negedge mclk);
    while (reg_ready !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    reg_sel = s;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = ~s;
    reg_wdata = ~d;
    if (n == 20) tb_top.timeout();
  endtask
  task automatic rd(input logic [1:0] s, output logic [15:0] d);
    int n;
    n = 0;
    go(s, 16'h0000, 1'b0);
    while (reg_rvalid !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    d = reg_rdata;
    if (n == 20) tb_top.timeout();
  endtask
endmodule // cmw_host

// ===== sim/tb_top.sv
/* Self-checking bench for the command memory access window.
   Assumes the host model issues all register traffic. */
`timescale 1ns/10ps
module tb_top;
  import cmw_pkg::*;
  logic mclk, rst_n, st_done, reg_wr, reg_rd, reg_ready, reg_rvalid, init_busy;
  logic [1:0] st_result, reg_sel;
  logic [15:0] st_diag, fw_version, reg_wdata, reg_rdata, a, d, e;
  logic [15:0] mem [CMW_MEM_WORDS];
  logic [9:0] w;
  logic [9:0] q[$];
  logic [9:0] cw [6] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h025, 10'h3FF};
  int seed = 32'hCD58;
  int err_count = 0;
  int n_compared = 0;
  cmw_window dut (.*);
  cmw_host u_host (.*);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task timeout;
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    test_done();
  endtask
  function automatic logic [15:0] code(input logic [1:0] r);
    return r == 2'h0 ? CMW_RES_PASS : (r == 2'h1 ? CMW_RES_FAIL : CMW_RES_SKIP);
  endfunction
  initial
  begin
    rst_n = 1'b0;
    st_done = 1'b0;
    st_result = 2'h0;
    st_diag = 16'h0000;
    fw_version = 16'h0000;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      u_host.go(CMW_SEL_ADDR, 16'hFFFF, 1'b1);
      st_result = r[1:0];
      st_diag = 16'($random(seed));
      fw_version = 16'($random(seed));
      @(negedge mclk);
      st_done = 1'b1;
      @(negedge mclk);
      st_done = 1'b0;
      chk({15'h0000, init_busy}, 16'h0001);
      chk({15'h0000, reg_ready}, 16'h0000);
      repeat (2) @(negedge mclk);
      chk({15'h0000, init_busy}, 16'h0000);
      u_host.rd(CMW_SEL_ADDR, d);
      chk(d, fw_version);
      u_host.rd(CMW_SEL_LOW, d);
      chk(d, code(st_result));
      chk({15'h0000, d == CMW_RES_PASS || d == CMW_RES_FAIL || d == CMW_RES_SKIP}, 16'h0001);
      u_host.rd(CMW_SEL_HIGH, d);
      chk(d, r == 1 ? st_diag : CMW_HIGH_CLEAN);
    end
    $display("test self-test done");
    for (int i = 0; i < 48; i++)
    begin
      w = i < 6 ? cw[i] : 10'($random(seed));
      a = 16'($random(seed));
      e = 16'($random(seed));
      // longword at or below the word, noise in spare bits
      a = {a[15:11], w[9:1], a[1:0]};
      u_host.go(CMW_SEL_ADDR, a, 1'b1);
      u_host.rd(CMW_SEL_ADDR, d);
      chk(d, a & CMW_OFS_MASK);
      u_host.go(w[0] ? CMW_SEL_HIGH : CMW_SEL_LOW, e, 1'b1);
      mem[w] = e;
      q.push_back(w);
    end
    u_host.go(2'h3, 16'hFFFF, 1'b1);
    u_host.rd(2'h3, d);
    chk(d, 16'h0000);
    $display("test random writes done");
    foreach (q[i])
    begin
      w = q[i];
      u_host.go(CMW_SEL_ADDR, {5'h00, w[9:1], 2'h0}, 1'b1);
      u_host.rd(w[0] ? CMW_SEL_HIGH : CMW_SEL_LOW, d);
      chk(d, mem[w]);
    end
    $display("test readback done");
    u_host.go(CMW_SEL_ADDR, 16'h0000, 1'b1);
    u_host.go(CMW_SEL_LOW, 16'(CMW_UNIT_BYTES), 1'b1);
    u_host.go(CMW_SEL_HIGH, 16'(2 * CMW_UNIT_BYTES), 1'b1);
    u_host.go(CMW_SEL_ADDR, 16'h0004, 1'b1);
    u_host.go(CMW_SEL_HIGH, 16'h0000, 1'b1);
    u_host.go(CMW_SEL_LOW, e, 1'b1);
    u_host.rd(CMW_SEL_LOW, d);
    chk(d, e);
    u_host.rd(CMW_SEL_HIGH, d);
    chk(d, 16'h0000);
    u_host.go(CMW_SEL_ADDR, 16'h0000, 1'b1);
    u_host.rd(CMW_SEL_HIGH, d);
    chk(d, 16'(2 * CMW_UNIT_BYTES));
    u_host.rd(CMW_SEL_LOW, d);
    chk(d, 16'(CMW_UNIT_BYTES));
    u_host.go(CMW_SEL_ADDR, 16'((CMW_UNITS - 1) * CMW_UNIT_BYTES), 1'b1);
    u_host.go(CMW_SEL_LOW, ~e, 1'b1);
    u_host.rd(CMW_SEL_LOW, d);
    chk(d, ~e);
    $display("test init block done");
    test_done();
  end
endmodule // tb_top
